// File: watchdog_defs.svh
// Constants of the watchdog block: register indices, field positions, reset values.
// Assumes the includer places byte address = 4 * index on the register bus.
`ifndef WATCHDOG_DEFS_SVH
`define WATCHDOG_DEFS_SVH

`define WDT_IDX_W 14
`define WDT_OPTION_IDX 14'h0081
`define WDT_CONFIG_IDX 14'h2007
`define WDT_STATUS_IDX 14'h0003

`define WDT_OPT_PSA_BIT 3
`define WDT_OPT_PS_MSB 2
`define WDT_OPT_PS_LSB 0
`define WDT_CFG_FUSE_BIT 2

`define WDT_OPTION_RST 8'hff
`define WDT_CONFIG_RST 8'h00
`define WDT_COUNT_CLEAR 8'h00
`define WDT_BASE_LAST 8'hff

`endif

// File: watchdog_pkg.sv
// Types shared by the watchdog block.
// Assumes watchdog_defs.svh is on the include path.
package watchdog_pkg;

  typedef enum logic {PWR_RUN, PWR_SLEEP} power_state_e;

  typedef struct packed {
    logic read;
    logic write;
    logic [15:0] address;
    logic [31:0] writedata;
    logic [3:0] byteenable;
  } avs_req_s;

  typedef struct packed {
    logic timeout_status_n;
    logic powerdown_status_n;
  } wdt_flags_s;

endpackage : watchdog_pkg

// File: watchdog_timer.sv
// Watchdog timer with sleep wake-up, shared postscaler and Avalon-MM registers.
// Assumes instruction strobes come from core logic on core_clk_i; the oscillator
// tick and the configuration strap arrive from outside and are synchronised here.
//
// What this block does
// RL1 - Watchdog counts its own oscillator, also in sleep.
// RL2 - Expiry while running raises a watchdog reset.
// RL3 - Expiry during sleep wakes the device instead.
// RL4 - Every expiry drives the time-out flag low.
// RL5 - Cleared enable fuse keeps the watchdog off.
// RL6 - One postscaler shared with the basic timer.
// RL7 - Clear or sleep zeroes counter and assigned postscaler.
// RL8 - Clear zeroes prescaler count, keeps its assignment.
// RL9 - Sleep: counter 00h, time-out flag high, power-down flag low, oscillator stopped.
// RL10 - Base period is a parameter, times postscaler ratio.
//
// Decided for this implementation: the Avalon-MM slave port.
`include "watchdog_defs.svh"

module watchdog_timer
  import watchdog_pkg::*;
#(
  parameter logic [7:0] WDT_LAST = `WDT_BASE_LAST
)
(
  // Clock, reset and enable.
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  // Watchdog oscillator and configuration strap pins.
  input wire logic wdt_osc_i,
  input wire logic [7:0] config_strap_i,
  // Core instruction strobes and basic timer clock.
  input wire logic watchdog_clear_instr_i,
  input wire logic sleep_instr_i,
  input wire logic basic_timer_tick_i,
  // Avalon-MM slave.
  input wire logic [15:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // Device control and status.
  output logic wdt_reset_o,
  output logic wake_o,
  output logic osc_stop_o,
  output logic timeout_status_n_o,
  output logic powerdown_status_n_o,
  output logic basic_timer_inc_o
);

  // Postscaler terminal count: 2**ps - 1 for the watchdog, 2**(ps+1) - 1 for the timer.
  function automatic logic [7:0] ratio_mask(input logic [2:0] ps, input logic for_wdt);
    logic [8:0] ratio;
    ratio = for_wdt ? (9'h001 << ps) : (9'h002 << ps);
    return 8'(ratio - 9'h001);
  endfunction : ratio_mask

  avs_req_s req;
  wdt_flags_s flags_ff;
  wdt_flags_s nxt_flags;
  power_state_e state_ff;
  power_state_e nxt_state;

  logic osc_meta_ff;
  logic osc_sync_ff;
  logic osc_prev_ff;
  logic [7:0] strap_meta_ff;
  logic [7:0] strap_sync_ff;
  logic captured_ff;
  logic nxt_captured;
  logic [7:0] config_word_ff;
  logic [7:0] nxt_config_word;
  logic [7:0] option_ff;
  logic [7:0] nxt_option;
  logic [7:0] count_ff;
  logic [7:0] nxt_count;
  logic [7:0] pre_ff;
  logic [7:0] nxt_pre;
  logic wdt_reset_ff;
  logic nxt_wdt_reset;
  logic wake_ff;
  logic nxt_wake;
  logic osc_stop_ff;
  logic nxt_osc_stop;
  logic timer_inc_ff;
  logic nxt_timer_inc;
  logic [31:0] readdata_ff;
  logic [31:0] nxt_readdata;
  logic waitreq_ff;
  logic nxt_waitreq;

  logic osc_tick;
  logic fuse_on;
  logic wdt_assigned;
  logic [2:0] ps;
  logic expire;
  logic instr_clear;
  logic instr_sleep;
  logic [`WDT_IDX_W-1:0] idx;
  logic [31:0] rd_mux;
  logic wr_take;

  assign req.read = avs_read_i;
  assign req.write = avs_write_i;
  assign req.address = avs_address_i;
  assign req.writedata = avs_writedata_i;
  assign req.byteenable = avs_byteenable_i;

  // Synchroniser and edge detector for the watchdog oscillator pin.
  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      osc_meta_ff <= 1'b0;
      osc_sync_ff <= 1'b0;
      osc_prev_ff <= 1'b0;
    end
    else if (ce_i)
    begin
      osc_meta_ff <= wdt_osc_i;
      osc_sync_ff <= osc_meta_ff;
      osc_prev_ff <= osc_sync_ff;
    end
  end

  // No reset here, so the strap level is already settled when reset ends.
  always_ff @(posedge core_clk_i)
  begin
    if (ce_i)
    begin
      strap_meta_ff <= config_strap_i;
      strap_sync_ff <= strap_meta_ff;
    end
  end

  // The watchdog advances only on edges of its own oscillator, sampled on core_clk_i,
  // so sleep does not stop it, but a halted core_clk_i does.
  assign osc_tick = osc_sync_ff & ~osc_prev_ff; // RL1

  assign fuse_on = config_word_ff[`WDT_CFG_FUSE_BIT]; // RL5
  assign wdt_assigned = option_ff[`WDT_OPT_PSA_BIT]; // RL6
  assign ps = option_ff[`WDT_OPT_PS_MSB:`WDT_OPT_PS_LSB]; // RL6

  // Instructions are not executed while the core sleeps.
  assign instr_clear = watchdog_clear_instr_i & (state_ff == PWR_RUN);
  assign instr_sleep = sleep_instr_i & (state_ff == PWR_RUN);

  assign idx = req.address[15:2];
  assign wr_take = req.write & ~req.read & ~waitreq_ff;

  always_comb
  begin
    rd_mux = 32'h0000_0000;
    unique case (idx)
      `WDT_OPTION_IDX: rd_mux = {24'h00_0000, option_ff};
      `WDT_CONFIG_IDX: rd_mux = {24'h00_0000, config_word_ff};
      `WDT_STATUS_IDX: rd_mux = {16'h0000, count_ff, 5'h00, state_ff == PWR_SLEEP,
        flags_ff.powerdown_status_n, flags_ff.timeout_status_n};
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  always_comb
  begin
    nxt_count = count_ff;
    nxt_pre = pre_ff;
    nxt_flags = flags_ff;
    nxt_state = state_ff;
    nxt_option = option_ff;
    nxt_config_word = config_word_ff;
    nxt_captured = captured_ff;
    nxt_wdt_reset = 1'b0;
    nxt_wake = 1'b0;
    nxt_osc_stop = osc_stop_ff;
    nxt_timer_inc = 1'b0;
    nxt_readdata = readdata_ff;
    nxt_waitreq = 1'b1;
    expire = 1'b0;

    // The configuration word is caught once, after reset is released.
    if (!captured_ff)
    begin
      nxt_config_word = strap_sync_ff;
      nxt_captured = 1'b1;
    end

    // Watchdog counter and, when assigned, its postscaler.
    if (!fuse_on)
    begin
      nxt_count = `WDT_COUNT_CLEAR; // RL5
    end
    else if (osc_tick)
    begin
      if (count_ff == WDT_LAST) // RL10
      begin
        nxt_count = `WDT_COUNT_CLEAR;
        if (wdt_assigned)
        begin
          if (pre_ff == ratio_mask(ps, 1'b1)) // RL10
          begin
            nxt_pre = 8'h00;
            expire = 1'b1;
          end
          else
          begin
            nxt_pre = pre_ff + 8'h01; // RL6
          end
        end
        else
        begin
          expire = 1'b1;
        end
      end
      else
      begin
        nxt_count = count_ff + 8'h01;
      end
    end

    // Basic timer path through the same prescaler when it is not assigned.
    if (!wdt_assigned && basic_timer_tick_i)
    begin
      if (pre_ff == ratio_mask(ps, 1'b0))
      begin
        nxt_pre = 8'h00; // RL6
        nxt_timer_inc = 1'b1;
      end
      else
      begin
        nxt_pre = pre_ff + 8'h01;
      end
    end

    if (instr_clear || instr_sleep)
    begin
      nxt_count = `WDT_COUNT_CLEAR; // RL7
      if (wdt_assigned)
      begin
        nxt_pre = 8'h00; // RL7
      end
    end

    // The option register, and so the assignment bit, is left as it stands.
    if (instr_clear)
    begin
      nxt_pre = 8'h00; // RL8
      nxt_flags.timeout_status_n = 1'b1;
      nxt_flags.powerdown_status_n = 1'b1;
    end

    if (instr_sleep)
    begin
      nxt_pre = 8'h00; // RL9
      nxt_flags.timeout_status_n = 1'b1; // RL9
      nxt_flags.powerdown_status_n = 1'b0; // RL9
      nxt_state = PWR_SLEEP; // RL9
      nxt_osc_stop = 1'b1; // RL9
    end

    // An expiry wins over a clear or sleep issued in the same cycle.
    if (expire)
    begin
      nxt_flags.timeout_status_n = 1'b0; // RL4
      unique case (state_ff)
        PWR_RUN:
        begin
          nxt_wdt_reset = 1'b1; // RL2
          nxt_state = PWR_RUN;
          nxt_osc_stop = 1'b0;
        end
        PWR_SLEEP:
        begin
          nxt_wake = 1'b1; // RL3
          nxt_state = PWR_RUN; // RL3
          nxt_osc_stop = 1'b0; // RL3
        end
      endcase
    end

    // Avalon slave: one wait cycle, then the answer with waitrequest low.
    if ((req.read ^ req.write) && waitreq_ff)
    begin
      nxt_waitreq = 1'b0;
      nxt_readdata = req.read ? rd_mux : 32'h0000_0000;
    end

    if (wr_take && idx == `WDT_OPTION_IDX && req.byteenable[0])
    begin
      nxt_option = req.writedata[7:0]; // RL6
    end
  end

  always_ff @(posedge core_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      count_ff <= `WDT_COUNT_CLEAR;
      pre_ff <= 8'h00;
      flags_ff <= 2'b11;
      state_ff <= PWR_RUN;
      option_ff <= `WDT_OPTION_RST;
      config_word_ff <= `WDT_CONFIG_RST;
      captured_ff <= 1'b0;
      wdt_reset_ff <= 1'b0;
      wake_ff <= 1'b0;
      osc_stop_ff <= 1'b0;
      timer_inc_ff <= 1'b0;
      readdata_ff <= 32'h0000_0000;
      waitreq_ff <= 1'b1;
    end
    else if (ce_i)
    begin
      count_ff <= nxt_count;
      pre_ff <= nxt_pre;
      flags_ff <= nxt_flags;
      state_ff <= nxt_state;
      option_ff <= nxt_option;
      config_word_ff <= nxt_config_word;
      captured_ff <= nxt_captured;
      wdt_reset_ff <= nxt_wdt_reset;
      wake_ff <= nxt_wake;
      osc_stop_ff <= nxt_osc_stop;
      timer_inc_ff <= nxt_timer_inc;
      readdata_ff <= nxt_readdata;
      waitreq_ff <= nxt_waitreq;
    end
  end

  assign avs_readdata_o = readdata_ff;
  assign avs_waitrequest_o = waitreq_ff;
  assign wdt_reset_o = wdt_reset_ff;
  assign wake_o = wake_ff;
  assign osc_stop_o = osc_stop_ff;
  assign timeout_status_n_o = flags_ff.timeout_status_n;
  assign powerdown_status_n_o = flags_ff.powerdown_status_n;
  assign basic_timer_inc_o = timer_inc_ff;

endmodule : watchdog_timer

// File: watchdog_timer_bench.sv
// Self-checking bench for the watchdog block with a shortened base count.
// Assumes watchdog_pkg is compiled first and watchdog_defs.svh is reachable.
module watchdog_timer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst, osc, clr, slp, btick, rd, wr;
  logic wreq, wrst, wake, ostop, tmo_n, pwrdn_n, binc;
  logic [7:0] strap;
  logic [15:0] addr;
  logic [31:0] wdat, rdat, q;
  int errors, tests_run, rst_cnt, wake_cnt, inc_cnt, b;

  watchdog_timer #(.WDT_LAST(8'h03)) i_watchdog_timer (
    .core_clk_i(clk), .rst_i(rst), .ce_i(1'b1), .wdt_osc_i(osc), .config_strap_i(strap),
    .watchdog_clear_instr_i(clr), .sleep_instr_i(slp), .basic_timer_tick_i(btick),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdat),
    .avs_byteenable_i(4'hf), .avs_readdata_o(rdat), .avs_waitrequest_o(wreq),
    .wdt_reset_o(wrst), .wake_o(wake), .osc_stop_o(ostop), .timeout_status_n_o(tmo_n),
    .powerdown_status_n_o(pwrdn_n), .basic_timer_inc_o(binc)
  );

  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Pulse counters see the values settled before each edge.
  always @(posedge clk)
  begin
    rst_cnt += (wrst === 1'b1);
    wake_cnt += (wake === 1'b1);
    inc_cnt += (binc === 1'b1);
  end

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd <= !w;
    wr <= w;
    wdat <= {24'h0, d};
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus

  task tick(input int n);
    repeat (n)
    begin
      @(posedge clk) osc <= 1'b1;
      repeat (3) @(posedge clk);
      osc <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (3) @(posedge clk);
  endtask : tick

  task instr(input logic s);
    @(posedge clk);
    slp <= s;
    clr <= !s;
    @(posedge clk);
    slp <= 1'b0;
    clr <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : instr

  task restart(input logic [7:0] s);
    rst <= 1'b1;
    strap <= s;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
  endtask : restart

  task t_fuse;
    restart(8'h00);
    bus(1'b1, 16'h0204, 8'h08);
    instr(1'b0);
    b = rst_cnt;
    tick(8);
    chk("reset count fuse off", b, rst_cnt);
    $display("test fuse done");
  endtask : t_fuse

  task t_regs;
    restart(8'h04);
    bus(1'b0, 16'h0204, 8'h00);
    chk("option reset", 32'hff, q);
    bus(1'b1, 16'h801c, 8'h00);
    bus(1'b0, 16'h801c, 8'h00);
    chk("config word", 32'h04, q);
    bus(1'b0, 16'h0010, 8'h00);
    chk("unmapped read", 32'h0, q);
    bus(1'b0, 16'h000c, 8'h00);
    chk("status flags", 32'h3, {30'h0, q[1:0]});
    $display("test regs done");
  endtask : t_regs

  task t_run;
    bus(1'b1, 16'h0204, 8'h08);
    instr(1'b0);
    b = rst_cnt;
    tick(3);
    chk("reset count early", b, rst_cnt);
    tick(1);
    chk("reset count expiry", b + 1, rst_cnt);
    chk("time-out flag", 1'b0, tmo_n);
    instr(1'b0);
    chk("time-out flag cleared", 1'b1, tmo_n);
    tick(3);
    instr(1'b0);
    tick(3);
    chk("reset count cleared", b + 1, rst_cnt);
    bus(1'b0, 16'h0204, 8'h00);
    chk("option kept", 32'h08, q);
    $display("test run done");
  endtask : t_run

  task t_ratio;
    bus(1'b1, 16'h0204, 8'h09);
    instr(1'b0);
    b = rst_cnt;
    tick(7);
    chk("reset count ratio early", b, rst_cnt);
    tick(1);
    chk("reset count ratio", b + 1, rst_cnt);
    $display("test ratio done");
  endtask : t_ratio

  task t_sleep;
    bus(1'b1, 16'h0204, 8'h08);
    instr(1'b1);
    chk("sleep flags", 3'b101, {ostop, pwrdn_n, tmo_n});
    bus(1'b0, 16'h000c, 8'h00);
    chk("status asleep", 32'h5, q);
    b = rst_cnt;
    tick(4);
    chk("wake count", 1, wake_cnt);
    chk("reset count asleep", b, rst_cnt);
    chk("wake flags", 2'b00, {ostop, tmo_n});
    $display("test sleep done");
  endtask : t_sleep

  task t_shared;
    bus(1'b1, 16'h0204, 8'h00);
    instr(1'b0);
    b = inc_cnt;
    repeat (2)
    begin
      @(posedge clk) btick <= 1'b1;
      @(posedge clk) btick <= 1'b0;
    end
    repeat (2) @(posedge clk);
    chk("basic timer carry", b + 1, inc_cnt);
    b = rst_cnt;
    tick(4);
    chk("reset count unscaled", b + 1, rst_cnt);
    $display("test shared done");
  endtask : t_shared

  task print_verdict;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict

  initial
  begin
    #800000;
    errors++;
    print_verdict();
  end

  initial
  begin
    {rst, osc, clr, slp, btick, rd, wr} = 7'h40;
    strap = 8'h00;
    addr = 16'h0;
    wdat = 32'h0;
    t_fuse();
    t_regs();
    t_run();
    t_ratio();
    t_sleep();
    t_shared();
    print_verdict();
  end
endmodule : watchdog_timer_bench

// File: watchdog_timer_sva.sv
// Port checker for the watchdog block.
// Assumes one clock domain and ce_i held high by its surroundings.
module watchdog_timer_sva
#(
  parameter logic [7:0] WDT_LAST = 8'hff
)
(
  // Clock and reset.
  input wire logic core_clk_i,
  input wire logic rst_i,
  // Bus and instruction inputs.
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic sleep_instr_i,
  input wire logic watchdog_clear_instr_i,
  // Watched outputs.
  input wire logic avs_waitrequest_o,
  input wire logic wdt_reset_o,
  input wire logic wake_o,
  input wire logic osc_stop_o,
  input wire logic timeout_status_n_o,
  input wire logic powerdown_status_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge core_clk_i);
  endclocking
  default disable iff (rst_i);
  sequence req_seen_q;
    (avs_read_i ^ avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence asleep_q;
    osc_stop_o && !powerdown_status_n_o && timeout_status_n_o;
  endsequence
  bus_answer_a: assert property (req_seen_q |=> !avs_waitrequest_o)
    else $error("bus request not answered in one cycle");
  wait_single_a: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  sleep_entry_a: assert property (sleep_instr_i && !osc_stop_o |=> asleep_q)
    else $error("sleep did not set flags and stop oscillator");
  clear_flags_a: assert property (watchdog_clear_instr_i && !osc_stop_o |=> timeout_status_n_o)
    else $error("clear did not restore time-out flag");
  reset_flag_a: assert property (wdt_reset_o |-> !timeout_status_n_o)
    else $error("watchdog reset without time-out flag low");
  reset_running_a: assert property (wdt_reset_o |-> !$past(osc_stop_o))
    else $error("watchdog reset raised while asleep");
  wake_flag_a: assert property (wake_o |-> !osc_stop_o && !timeout_status_n_o)
    else $error("wake without restart or time-out flag");
  wake_sleep_a: assert property (wake_o |-> $past(osc_stop_o))
    else $error("wake raised while running");
  reset_pulse_a: assert property (wdt_reset_o |=> !wdt_reset_o)
    else $error("watchdog reset longer than one cycle");
endmodule : watchdog_timer_sva

bind watchdog_timer watchdog_timer_sva #(.WDT_LAST(WDT_LAST)) i_watchdog_timer_sva (
  .core_clk_i(core_clk_i),
  .rst_i(rst_i),
  .avs_read_i(avs_read_i),
  .avs_write_i(avs_write_i),
  .sleep_instr_i(sleep_instr_i),
  .watchdog_clear_instr_i(watchdog_clear_instr_i),
  .avs_waitrequest_o(avs_waitrequest_o),
  .wdt_reset_o(wdt_reset_o),
  .wake_o(wake_o),
  .osc_stop_o(osc_stop_o),
  .timeout_status_n_o(timeout_status_n_o),
  .powerdown_status_n_o(powerdown_status_n_o)
);
